// File: shared/eba_pkg.sv
// eba_pkg: shared constants and types for the external bus arbitration link
// assumes both ends run on clk_sys at 100 MHz with one asynchronous active-low reset
package eba_pkg;
	localparam int CLK_MHZ = 100;
	// core rate at and above which the asynchronous option is mandatory
	localparam int ASYNC_REQUIRED_MHZ = 100;
	// cycles the busy line is driven high before it is released
	localparam int RELEASE_DRIVE_CYCLES = 1;
	localparam logic [1:0] RELEASE_CNT_INIT = 2'(RELEASE_DRIVE_CYCLES);
	// reset levels of the active-low lines
	localparam logic REQ_RESET_N = 1'b1;
	localparam logic GRANT_RESET_N = 1'b1;
	typedef enum logic [1:0] {ST_SLAVE, ST_PENDING, ST_MASTER, ST_RELEASE} eba_state_e;
	typedef enum logic [1:0] {AR_IDLE, AR_WAIT_FREE, AR_GRANTED} eba_arb_state_e;
endpackage

// File: shared/eba_if.sv
// eba_if: the three arbitration lines between a bus master and the external arbiter
// assumes the bench resolves the busy wire from the enables, with a pull-up when nobody drives
`timescale 1ns/1ps
interface eba_if;
	logic busRequestOut_n;
	logic busGrantIn_n;
	logic busBusyOut;
	logic busBusyOe;
	logic busBusyIn;
	logic otherBusyOut;
	logic otherBusyOe;
	modport master (output busRequestOut_n, input busGrantIn_n, output busBusyOut, output busBusyOe,
		input busBusyIn);
	modport arbiter (input busRequestOut_n, output busGrantIn_n, output otherBusyOut, output otherBusyOe,
		input busBusyIn);
endinterface

// File: hdl/eba_master.sv
// eba_master: the device end; requests, takes, parks and releases the external bus
// assumes the arbiter end drives grant and a wired busy line with external pull-up
//
// Behaviour
// - request output always driven, never floated
// - request asserted while wanting bus, dropped after
// - request changes as master or slave
// - request may drop while master, bus parks
// - request-hold bit keeps request asserted
// - only external accesses raise request
// - reset deasserts request, returns to slave
// - arbiter asserts grant for next master
// - take mastership only after busy seen free
// - grant removal ends mastership after cycle
// - default sampling synchronous to output clock
// - async bit treats grant, busy asynchronously
// - async option required at 100 MHz; code resets to sync and leaves the choice to asyncArbitrationEnable
// - master holds busy asserted while using bus
// - wait for busy free, then assert busy
// - master may hold busy while parked
// - release busy by driving high, then floating
`timescale 1ns/1ps
module eba_master
	import eba_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// configuration
	input wire logic requestHoldBit,
	input wire logic asyncArbitrationEnable,
	// access side
	input wire logic extAccessPending,
	input wire logic intAccessPending,
	input wire logic cycleDone,
	output logic busOwned,
	output logic cycleGo,
	// arbitration lines
	eba_if.master link
);
	eba_state_e state_reg, state_next;
	logic reqN_reg, reqN_next;
	logic bbOut_reg, bbOut_next;
	logic bbOe_reg, bbOe_next;
	logic owned_reg, owned_next;
	logic go_reg, go_next;
	logic inCycle_reg, inCycle_next;
	logic [1:0] relCnt_reg, relCnt_next;
	logic grantMeta_reg, grantSync_reg;
	logic grantMeta_next, grantSync_next;
	logic busyMeta_reg, busySync_reg;
	logic busyMeta_next, busySync_next;
	// sampling mode in force for the current tenure
	logic asyncMode_reg, asyncMode_next;
	logic grantSeen, busySeen;
	logic wantBus;

	// all three lines are active low; one place turns a level into an asserted flag
	function automatic logic lineAsserted(input logic levelN);
		return !levelN;
	endfunction

	// the two-stage synchronisers run in both modes, so a switch to the asynchronous
	// view never starts from stale flops; the mode is only taken over while slave, so
	// one tenure never mixes the direct and the synchronised view of grant and busy
	always_comb begin
		grantMeta_next = link.busGrantIn_n;
		grantSync_next = grantMeta_reg;
		busyMeta_next = link.busBusyIn;
		busySync_next = busyMeta_reg;
		asyncMode_next = asyncMode_reg;
		if (state_reg == ST_SLAVE) begin
			// at this clock rate only the asynchronous setting is safe on real pins
			asyncMode_next = asyncArbitrationEnable;
		end
	end

	// reset values read as idle lines, so nothing is taken for a grant in reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			grantMeta_reg <= GRANT_RESET_N;
			grantSync_reg <= GRANT_RESET_N;
			busyMeta_reg <= 1'b1;
			busySync_reg <= 1'b1;
			// power-up default is the synchronous view
			asyncMode_reg <= 1'b0;
		end else begin
			grantMeta_reg <= grantMeta_next;
			grantSync_reg <= grantSync_next;
			busyMeta_reg <= busyMeta_next;
			busySync_reg <= busySync_next;
			asyncMode_reg <= asyncMode_next;
		end
	end

	// grant and busy as asserted flags; sync mode samples the pins directly
	always_comb begin
		if (asyncMode_reg) begin
			grantSeen = lineAsserted(grantSync_reg);
			busySeen = lineAsserted(busySync_reg);
		end else begin
			grantSeen = lineAsserted(link.busGrantIn_n);
			busySeen = lineAsserted(link.busBusyIn);
		end
	end

	// internal activity never enters here, so it cannot touch the request
	assign wantBus = extAccessPending || requestHoldBit;

	// arbitration state machine; the request follows the need in every state
	always_comb begin
		state_next = state_reg;
		reqN_next = !wantBus;
		bbOut_next = bbOut_reg;
		bbOe_next = bbOe_reg;
		owned_next = owned_reg;
		go_next = 1'b0;
		inCycle_next = inCycle_reg;
		relCnt_next = relCnt_reg;
		unique case (state_reg)
			ST_SLAVE: begin
				// a grant with nothing to do is left alone; the arbiter may be parking it here
				if (grantSeen && wantBus) begin
					state_next = ST_PENDING;
				end
			end
			ST_PENDING: begin
				if (!grantSeen) begin
					state_next = ST_SLAVE;
				end else if (!wantBus) begin
					// the need went away while waiting: do not take a bus nobody asked for
					state_next = ST_SLAVE;
				end else if (busySeen) begin
					// another master still holds the line; wait for it to float high
					state_next = ST_PENDING;
				end else begin
					state_next = ST_MASTER;
					bbOut_next = 1'b0;
					bbOe_next = 1'b1;
					owned_next = 1'b1;
				end
			end
			ST_MASTER: begin
				// busy stays low while parked, with or without request
				// a cycle on the bus always finishes, even once the grant is gone
				if (inCycle_reg) begin
					if (cycleDone) begin
						inCycle_next = 1'b0;
					end
				end else if (!grantSeen) begin
					state_next = ST_RELEASE;
					// drive high first: the pull-up alone would be slow to lift the line
					bbOut_next = 1'b1;
					owned_next = 1'b0;
					relCnt_next = RELEASE_CNT_INIT;
				end else if (extAccessPending) begin
					go_next = 1'b1;
					inCycle_next = 1'b1;
				end
			end
			ST_RELEASE: begin
				if (relCnt_reg == 2'h1) begin
					// let go; the pull-up holds the line high from here
					bbOe_next = 1'b0;
					state_next = ST_SLAVE;
				end
				relCnt_next = relCnt_reg - 2'h1;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			// reset leaves a slave that neither asks for nor drives the bus
			state_reg <= ST_SLAVE;
			reqN_reg <= REQ_RESET_N;
			bbOut_reg <= 1'b1;
			bbOe_reg <= 1'b0;
			owned_reg <= 1'b0;
			go_reg <= 1'b0;
			inCycle_reg <= 1'b0;
			relCnt_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			reqN_reg <= reqN_next;
			bbOut_reg <= bbOut_next;
			bbOe_reg <= bbOe_next;
			owned_reg <= owned_next;
			go_reg <= go_next;
			inCycle_reg <= inCycle_next;
			relCnt_reg <= relCnt_next;
		end
	end

	// request has no enable: it is always driven
	assign link.busRequestOut_n = reqN_reg;
	// busy drive and enable come from flops, so the line never glitches on a state change
	assign link.busBusyOut = bbOut_reg;
	assign link.busBusyOe = bbOe_reg;
	assign busOwned = owned_reg;
	assign cycleGo = go_reg;
	// intAccessPending is accepted but deliberately left without effect
	logic unusedInt;
	assign unusedInt = intAccessPending;
endmodule

// File: hdl/eba_arbiter.sv
// eba_arbiter: the far end; grants the bus to the device against another master
// assumes the other master's request comes from the user side, synchronous to clk_sys
`timescale 1ns/1ps
module eba_arbiter
	import eba_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// other master
	input wire logic otherRequest,
	output logic otherOwned,
	// arbitration lines
	eba_if.arbiter link
);
	eba_arb_state_e state_reg, state_next;
	logic grantN_reg, grantN_next;
	logic bbOut_reg, bbOut_next;
	logic bbOe_reg, bbOe_next;
	logic owned_reg, owned_next;
	logic [1:0] relCnt_reg, relCnt_next;
	logic devReq, busFree;

	assign devReq = !link.busRequestOut_n;
	assign busFree = link.busBusyIn;

	// device has priority; parks with device until other master asks
	always_comb begin
		state_next = state_reg;
		grantN_next = grantN_reg;
		bbOut_next = bbOut_reg;
		bbOe_next = bbOe_reg;
		owned_next = owned_reg;
		relCnt_next = relCnt_reg;
		unique case (state_reg)
			AR_IDLE: begin
				if (devReq) begin
					grantN_next = 1'b0;
					state_next = AR_GRANTED;
				end else if (otherRequest) begin
					state_next = AR_WAIT_FREE;
				end
			end
			AR_GRANTED: begin
				if (otherRequest && !devReq) begin
					grantN_next = 1'b1;
					state_next = AR_WAIT_FREE;
				end
			end
			AR_WAIT_FREE: begin
				if (owned_reg) begin
					if (!otherRequest || devReq) begin
						bbOut_next = 1'b1;
						owned_next = 1'b0;
						relCnt_next = RELEASE_CNT_INIT;
					end
					if (relCnt_reg == 2'h1) begin
						bbOe_next = 1'b0;
						state_next = AR_IDLE;
					end
				end else if (relCnt_reg != 2'h0) begin
					if (relCnt_reg == 2'h1) begin
						bbOe_next = 1'b0;
						state_next = AR_IDLE;
					end
				end else if (busFree) begin
					bbOut_next = 1'b0;
					bbOe_next = 1'b1;
					owned_next = 1'b1;
				end
				if (relCnt_reg != 2'h0) begin
					relCnt_next = relCnt_reg - 2'h1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= AR_IDLE;
			grantN_reg <= GRANT_RESET_N;
			bbOut_reg <= 1'b1;
			bbOe_reg <= 1'b0;
			owned_reg <= 1'b0;
			relCnt_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			grantN_reg <= grantN_next;
			bbOut_reg <= bbOut_next;
			bbOe_reg <= bbOe_next;
			owned_reg <= owned_next;
			relCnt_reg <= relCnt_next;
		end
	end

	assign link.busGrantIn_n = grantN_reg;
	assign link.otherBusyOut = bbOut_reg;
	assign link.otherBusyOe = bbOe_reg;
	assign otherOwned = owned_reg;
endmodule

// File: verif/eba_sva.sv
// eba_sva: assertions on the arbitration lines between the two ends
// assumes one clock domain and a busy wire resolved by the bench
`timescale 1ns/1ps
module eba_sva (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// arbitration lines
	input wire logic busRequestOut_n,
	input wire logic busGrantIn_n,
	input wire logic busBusyOut,
	input wire logic busBusyOe,
	input wire logic busBusyIn,
	input wire logic otherBusyOut,
	input wire logic otherBusyOe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	reset_idle_a: assert property ($rose(rst_n) |-> busRequestOut_n && !busBusyOe)
		else $error("request or busy active after reset");
	take_low_a: assert property ($rose(busBusyOe) |-> !busBusyOut)
		else $error("busy not driven low on take");
	take_free_a: assert property ($rose(busBusyOe) |-> $past(busBusyIn))
		else $error("bus taken while busy");
	take_granted_a: assert property ($rose(busBusyOe) |-> !$past(busGrantIn_n))
		else $error("bus taken without grant");
	park_hold_a: assert property (busBusyOe && !busBusyOut && !busGrantIn_n |=> busBusyOe && !busBusyOut)
		else $error("busy dropped while granted");
	release_short_a: assert property (busBusyOe && busBusyOut |=> !busBusyOe)
		else $error("busy driven high too long");
	release_high_a: assert property ($fell(busBusyOe) |-> $past(busBusyOut))
		else $error("busy floated without high drive");
	drive_excl_a: assert property (!(busBusyOe && otherBusyOe))
		else $error("two drivers on busy");
	grant_loss_a: assert property ($rose(busGrantIn_n) && busBusyOe |-> ##[1:20] !busBusyOe)
		else $error("bus kept after grant loss");
	take_c: cover property ($rose(busBusyOe));
	release_c: cover property (busBusyOe && busBusyOut);
	other_c: cover property ($rose(otherBusyOe) && !otherBusyOut);
endmodule

// File: verif/test_external_bus_arbitration.sv
// test_external_bus_arbitration: device end against arbiter end over one link
// assumes clk_sys at 100 MHz; inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module test_external_bus_arbitration;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic requestHoldBit = 1'b0;
	logic asyncArbitrationEnable = 1'b0;
	logic extAccessPending = 1'b0;
	logic intAccessPending = 1'b0;
	logic cycleDone = 1'b0;
	logic otherRequest = 1'b0;
	logic busOwned;
	logic cycleGo;
	logic otherOwned;
	int n_fail = 0;
	int num_checks = 0;
	int cycles = 0;
	eba_if link();
	// pull-up unless an enabled driver pulls low
	assign link.busBusyIn = ((link.busBusyOe && !link.busBusyOut) || (link.otherBusyOe && !link.otherBusyOut))
		? 1'b0 : 1'b1;
	eba_master eba_master_inst (.clk_sys(clk_sys), .rst_n(rst_n), .requestHoldBit(requestHoldBit),
		.asyncArbitrationEnable(asyncArbitrationEnable), .extAccessPending(extAccessPending),
		.intAccessPending(intAccessPending), .cycleDone(cycleDone), .busOwned(busOwned), .cycleGo(cycleGo),
		.link(link.master));
	eba_arbiter eba_arbiter_inst (.clk_sys(clk_sys), .rst_n(rst_n), .otherRequest(otherRequest),
		.otherOwned(otherOwned), .link(link.arbiter));
	eba_sva eba_sva_inst (.clk_sys(clk_sys), .rst_n(rst_n), .busRequestOut_n(link.busRequestOut_n),
		.busGrantIn_n(link.busGrantIn_n), .busBusyOut(link.busBusyOut), .busBusyOe(link.busBusyOe),
		.busBusyIn(link.busBusyIn), .otherBusyOut(link.otherBusyOut), .otherBusyOe(link.otherBusyOe));
	always #5 clk_sys = ~clk_sys;
	// whole run needs under a hundred cycles; ceiling leaves wide margin
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 4000) begin
			n_fail++;
			conclude();
		end
	end
	task conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task check(input logic seen, input logic exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// bounded waits; the caller judges the level reached
	task waitOwned(input logic v);
		for (int i = 0; i < 40 && busOwned !== v; i++) tick(1);
	endtask
	task waitGo();
		for (int i = 0; i < 40 && cycleGo !== 1'b1; i++) tick(1);
	endtask
	task take_and_yield(input logic async);
		asyncArbitrationEnable = async;
		intAccessPending = 1'b1;
		tick(3);
		check(link.busRequestOut_n, 1'b1);
		extAccessPending = 1'b1;
		tick(1);
		check(link.busRequestOut_n, 1'b0);
		waitOwned(1'b1);
		check(busOwned, 1'b1);
		check(link.busBusyIn, 1'b0);
		check(link.busGrantIn_n, 1'b0);
		waitGo();
		check(cycleGo, 1'b1);
		cycleDone = 1'b1;
		extAccessPending = 1'b0;
		tick(1);
		cycleDone = 1'b0;
		tick(4);
		check(busOwned, 1'b1);
		check(link.busRequestOut_n, 1'b1);
		extAccessPending = 1'b1;
		waitGo();
		check(cycleGo, 1'b1);
		extAccessPending = 1'b0;
		otherRequest = 1'b1;
		tick(8);
		// cycle still open, so the bus must stay with the device
		check(busOwned, 1'b1);
		cycleDone = 1'b1;
		tick(1);
		cycleDone = 1'b0;
		waitOwned(1'b0);
		check(busOwned, 1'b0);
		check(link.busGrantIn_n, 1'b1);
		for (int i = 0; i < 40 && otherOwned !== 1'b1; i++) tick(1);
		check(otherOwned, 1'b1);
		check(link.busBusyIn, 1'b0);
		otherRequest = 1'b0;
		intAccessPending = 1'b0;
		tick(8);
	endtask
	task hold_and_reset();
		requestHoldBit = 1'b1;
		tick(1);
		check(link.busRequestOut_n, 1'b0);
		waitOwned(1'b1);
		check(busOwned, 1'b1);
		rst_n = 1'b0;
		tick(1);
		check(link.busRequestOut_n, 1'b1);
		check(busOwned, 1'b0);
		check(link.busBusyOe, 1'b0);
		requestHoldBit = 1'b0;
		rst_n = 1'b1;
		tick(2);
	endtask
	initial begin
		tick(2);
		rst_n = 1'b1;
		tick(1);
		take_and_yield(1'b0);
		take_and_yield(1'b1);
		hold_and_reset();
		conclude();
	end
endmodule
